// ---- src/dpm_regs.svh ----
/*
 Register map constants for the drive parameter monitor register bank.
 Assumes one 16-bit holding-register access port on a single system clock.
*/
// Contract
// RL1: Life warning bits: capacitor aged, fan slow
// RL2: Frequency source codes 0..6 and 10
// RL3: Run source accepts codes 1 to 5
// RL4: Panel direction: 0 forward, 1 reverse
// RL5: Analog pair select accepts 0 to 4
// RL6: Auxiliary input role accepts 0 to 3
// RL7: Max 30..400 Hz, base 30..max
// RL8: Braking load rate 0..1000, 0.1 percent
// RL9: Wide values: upper half at lower address
`ifndef DPM_REGS_SVH
`define DPM_REGS_SVH
`define DPM_ENERGY_HI     16'h1013
`define DPM_ENERGY_LO     16'h1014
`define DPM_RUN_HI        16'h1015
`define DPM_RUN_LO        16'h1016
`define DPM_PWR_HI        16'h1017
`define DPM_PWR_LO        16'h1018
`define DPM_HEATSINK      16'h1019
`define DPM_MOTOR_TEMP    16'h101a
`define DPM_LIFE_WARN     16'h101d
`define DPM_DC_BUS        16'h1026
`define DPM_BRAKE_LOAD    16'h1027
`define DPM_THERMAL       16'h1028
`define DPM_PULSE_HI      16'h1034
`define DPM_PULSE_LO      16'h1035
`define DPM_POSCMD_HI     16'h1036
`define DPM_POSCMD_LO     16'h1037
`define DPM_POSACT_HI     16'h1038
`define DPM_POSACT_LO     16'h1039
`define DPM_ACCEL_HI      16'h1103
`define DPM_ACCEL_LO      16'h1104
`define DPM_DECEL_HI      16'h1105
`define DPM_DECEL_LO      16'h1106
`define DPM_DIRECTION     16'h1107
`define DPM_FREQ_SRC      16'h1201
`define DPM_RUN_SRC       16'h1202
`define DPM_BASE_FREQ     16'h1203
`define DPM_MAX_FREQ      16'h1204
`define DPM_ANALOG_PAIR   16'h1205
`define DPM_AUX_ROLE      16'h1206
`define DPM_LIFE_CAP_BIT  0
`define DPM_LIFE_FAN_BIT  1
`define DPM_FREQ_LIM_MIN  16'h001e
`define DPM_FREQ_LIM_MAX  16'h0190
`define DPM_BRAKE_MAX     16'h03e8
`define DPM_FREQ_SRC_MAX6 16'h0006
`define DPM_FREQ_SRC_CALC 16'h000a
`define DPM_RUN_SRC_MIN   16'h0001
`define DPM_RUN_SRC_MAX   16'h0005
`define DPM_PAIR_MAX      16'h0004
`define DPM_AUX_MAX       16'h0003
`define DPM_TIME_MIN      32'h0000_0001
`define DPM_TIME_MAX      32'h0005_7e40
`define DPM_RST_BASE      16'h003c
`define DPM_RST_MAX       16'h003c
`define DPM_RST_ACCEL     32'h0000_0bb8
`endif

// ---- src/dpm_pkg.sv ----
/*
 Types shared by the drive parameter monitor register bank.
 Assumes the register map header is included alongside.
*/
package dpm_pkg;
	typedef struct packed {
		logic [31:0] energy_total;
		logic [31:0] run_hours;
		logic [31:0] powered_hours;
		logic [15:0] heatsink_temp;
		logic [15:0] motor_temp;
		logic        cap_aged;
		logic        fan_slow;
		logic [15:0] dc_bus;
		logic [15:0] brake_load;
		logic [15:0] thermal_level;
		logic [31:0] position_cmd;
		logic [31:0] position_act;
	} dpm_monitor_t;

	typedef struct packed {
		logic [31:0] accel_time;
		logic [31:0] decel_time;
		logic        reverse;
		logic [3:0]  freq_source;
		logic [2:0]  run_source;
		logic [8:0]  base_freq;
		logic [8:0]  max_freq;
		logic [2:0]  analog_pair;
		logic [1:0]  aux_role;
	} dpm_setting_t;

	typedef enum logic [3:0] {
		DPM_FS_KNOB   = 4'h0,
		DPM_FS_TERM   = 4'h1,
		DPM_FS_PRESET = 4'h2,
		DPM_FS_SERIAL = 4'h3,
		DPM_FS_OPT1   = 4'h4,
		DPM_FS_OPT2   = 4'h5,
		DPM_FS_PULSE  = 4'h6,
		DPM_FS_UNUSED = 4'h7,
		DPM_FS_CALC   = 4'ha
	} dpm_freq_src_t;
endpackage

// ---- src/dpm_param_bank.sv ----
/*
 Holding-register bank of a motor drive: monitors, basic settings, function-mode selectors.
 Assumes a serial front end on the same clock presents one 16-bit access per strobe.
*/
`timescale 1ns/1ps
`include "dpm_regs.svh"
module dpm_param_bank
	import dpm_pkg::*;
(
	// Clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         srst_i,
	// Register access from the serial front end
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	input  wire logic [15:0]  reg_addr_i,
	input  wire logic [15:0]  reg_wdata_i,
	output logic [15:0]       reg_rdata_o,
	output logic              reg_ack_o,
	output logic              reg_err_o,
	// Drive state and settings
	input  wire dpm_monitor_t mon_i,
	input  wire logic         pulse_inc_i,
	output dpm_setting_t      set_o,
	output logic [31:0]       pulse_count_o
);
	dpm_setting_t set_r;
	logic [31:0]  pulse_r;
	logic [15:0]  hold_r;
	logic [15:0]  rdata_r;
	logic         ack_r;
	logic         err_r;
	logic [15:0]  rd_mux;
	logic         rd_hit;
	logic [31:0]  hi_word;
	logic [31:0]  lo_word;

	wire logic [15:0] wd = reg_wdata_i;
	wire logic [31:0] wide_wr = {hold_r, wd};
	wire logic time_ok = (wide_wr >= `DPM_TIME_MIN) && (wide_wr <= `DPM_TIME_MAX);
	// RL2 source code check
	wire logic fs_ok = (wd <= `DPM_FREQ_SRC_MAX6) || (wd == `DPM_FREQ_SRC_CALC);
	// RL3 run source range
	wire logic rs_ok = (wd >= `DPM_RUN_SRC_MIN) && (wd <= `DPM_RUN_SRC_MAX);
	// RL4 direction is one bit
	wire logic dir_ok = (wd[15:1] == 15'h0000);
	// RL5 pair range
	wire logic ap_ok = (wd <= `DPM_PAIR_MAX);
	// RL6 role range
	wire logic ar_ok = (wd <= `DPM_AUX_MAX);
	// RL7 frequency limits
	wire logic mx_ok = (wd >= `DPM_FREQ_LIM_MIN) && (wd <= `DPM_FREQ_LIM_MAX) && (wd >= {7'h00, set_r.base_freq});
	wire logic bs_ok = (wd >= `DPM_FREQ_LIM_MIN) && (wd <= {7'h00, set_r.max_freq});

	// RL9 upper half first at lower address
	assign hi_word = {16'h0000, hold_r};
	wire logic wr_hi  = reg_wr_i && ((reg_addr_i == `DPM_PULSE_HI) || (reg_addr_i == `DPM_ACCEL_HI) ||
		(reg_addr_i == `DPM_DECEL_HI));
	wire logic wr_pl  = reg_wr_i && (reg_addr_i == `DPM_PULSE_LO);
	// RL9 low half commits the pair
	wire logic wr_acc = reg_wr_i && (reg_addr_i == `DPM_ACCEL_LO) && time_ok;
	wire logic wr_dec = reg_wr_i && (reg_addr_i == `DPM_DECEL_LO) && time_ok;
	// RL4 direction write
	wire logic wr_dir = reg_wr_i && (reg_addr_i == `DPM_DIRECTION) && dir_ok;
	// RL2 source write
	wire logic wr_fs  = reg_wr_i && (reg_addr_i == `DPM_FREQ_SRC) && fs_ok;
	// RL3 run source write
	wire logic wr_rs  = reg_wr_i && (reg_addr_i == `DPM_RUN_SRC) && rs_ok;
	// RL7 frequency writes
	wire logic wr_bs  = reg_wr_i && (reg_addr_i == `DPM_BASE_FREQ) && bs_ok;
	wire logic wr_mx  = reg_wr_i && (reg_addr_i == `DPM_MAX_FREQ) && mx_ok;
	// RL5 pair write
	wire logic wr_ap  = reg_wr_i && (reg_addr_i == `DPM_ANALOG_PAIR) && ap_ok;
	// RL6 role write
	wire logic wr_ar  = reg_wr_i && (reg_addr_i == `DPM_AUX_ROLE) && ar_ok;
	wire logic wr_ok  = wr_hi || wr_pl || wr_acc || wr_dec || wr_dir || wr_fs || wr_rs || wr_bs || wr_mx ||
		wr_ap || wr_ar;
	// Low half of a wide monitor is latched on the high read so a pair stays consistent
	wire logic rd_wide_hi = (reg_addr_i == `DPM_ENERGY_HI) || (reg_addr_i == `DPM_RUN_HI) ||
		(reg_addr_i == `DPM_PWR_HI) || (reg_addr_i == `DPM_PULSE_HI) || (reg_addr_i == `DPM_POSCMD_HI) ||
		(reg_addr_i == `DPM_POSACT_HI);
	// RL8 clamp to full scale
	wire logic [15:0] brake_v = (mon_i.brake_load > `DPM_BRAKE_MAX) ? `DPM_BRAKE_MAX : mon_i.brake_load;
	// RL1 warning bits only
	wire logic [15:0] life_v = {14'h0000, mon_i.fan_slow, mon_i.cap_aged};

	always_comb begin
		rd_mux = 16'h0000;
		rd_hit = 1'b1;
		lo_word = 32'h0000_0000;
		case (reg_addr_i)
			`DPM_ENERGY_HI: begin
				rd_mux  = mon_i.energy_total[31:16];
				lo_word = mon_i.energy_total;
			end
			`DPM_RUN_HI: begin
				rd_mux  = mon_i.run_hours[31:16];
				lo_word = mon_i.run_hours;
			end
			`DPM_PWR_HI: begin
				rd_mux  = mon_i.powered_hours[31:16];
				lo_word = mon_i.powered_hours;
			end
			`DPM_PULSE_HI: begin
				rd_mux  = pulse_r[31:16];
				lo_word = pulse_r;
			end
			`DPM_POSCMD_HI: begin
				rd_mux  = mon_i.position_cmd[31:16];
				lo_word = mon_i.position_cmd;
			end
			`DPM_POSACT_HI: begin
				rd_mux  = mon_i.position_act[31:16];
				lo_word = mon_i.position_act;
			end
			// RL9 low half comes from the snapshot
			`DPM_ENERGY_LO,
			`DPM_RUN_LO,
			`DPM_PWR_LO,
			`DPM_PULSE_LO,
			`DPM_POSCMD_LO,
			`DPM_POSACT_LO: rd_mux = hi_word[15:0];
			`DPM_HEATSINK:  rd_mux = mon_i.heatsink_temp;
			`DPM_MOTOR_TEMP: rd_mux = mon_i.motor_temp;
			`DPM_LIFE_WARN: rd_mux = life_v;
			`DPM_DC_BUS:    rd_mux = mon_i.dc_bus;
			`DPM_BRAKE_LOAD: rd_mux = brake_v;
			`DPM_THERMAL:   rd_mux = mon_i.thermal_level;
			`DPM_ACCEL_HI:  rd_mux = set_r.accel_time[31:16];
			`DPM_ACCEL_LO:  rd_mux = set_r.accel_time[15:0];
			`DPM_DECEL_HI:  rd_mux = set_r.decel_time[31:16];
			`DPM_DECEL_LO:  rd_mux = set_r.decel_time[15:0];
			`DPM_DIRECTION: rd_mux = {15'h0000, set_r.reverse};
			`DPM_FREQ_SRC:  rd_mux = {12'h000, set_r.freq_source};
			`DPM_RUN_SRC:   rd_mux = {13'h0000, set_r.run_source};
			`DPM_BASE_FREQ: rd_mux = {7'h00, set_r.base_freq};
			`DPM_MAX_FREQ:  rd_mux = {7'h00, set_r.max_freq};
			`DPM_ANALOG_PAIR: rd_mux = {13'h0000, set_r.analog_pair};
			`DPM_AUX_ROLE:  rd_mux = {14'h0000, set_r.aux_role};
			default:        rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			set_r <= '{
				accel_time:  `DPM_RST_ACCEL,
				decel_time:  `DPM_RST_ACCEL,
				reverse:     1'b0,
				freq_source: 4'h0,
				run_source:  3'(`DPM_RUN_SRC_MIN),
				base_freq:   9'(`DPM_RST_BASE),
				max_freq:    9'(`DPM_RST_MAX),
				analog_pair: 3'h0,
				aux_role:    2'h0
			};
			pulse_r <= 32'h0000_0000;
			hold_r  <= 16'h0000;
			rdata_r <= 16'h0000;
			ack_r   <= 1'b0;
			err_r   <= 1'b0;
		end else begin
			ack_r <= reg_wr_i || reg_rd_i;
			err_r <= (reg_wr_i && !wr_ok) || (reg_rd_i && !rd_hit);
			if (reg_rd_i)
				rdata_r <= rd_hit ? rd_mux : 16'h0000;
			if (wr_hi)
				hold_r <= wd;
			else if (reg_rd_i && rd_wide_hi)
				hold_r <= lo_word[15:0];
			// RL9 write beats a same-cycle increment
			if (wr_pl)
				pulse_r <= wide_wr;
			else if (pulse_inc_i)
				pulse_r <= pulse_r + 32'h0000_0001;
			if (wr_acc)
				set_r.accel_time <= wide_wr;
			if (wr_dec)
				set_r.decel_time <= wide_wr;
			if (wr_dir)
				set_r.reverse <= wd[0];
			if (wr_fs)
				set_r.freq_source <= wd[3:0];
			if (wr_rs)
				set_r.run_source <= wd[2:0];
			if (wr_bs)
				set_r.base_freq <= wd[8:0];
			if (wr_mx)
				set_r.max_freq <= wd[8:0];
			if (wr_ap)
				set_r.analog_pair <= wd[2:0];
			if (wr_ar)
				set_r.aux_role <= wd[1:0];
		end
	end

	assign reg_rdata_o   = rdata_r;
	assign reg_ack_o     = ack_r;
	assign reg_err_o     = err_r;
	assign set_o         = set_r;
	assign pulse_count_o = pulse_r;

	a_max_freq_range: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL7
		(set_r.max_freq >= 9'(`DPM_FREQ_LIM_MIN)) && (set_r.max_freq <= 9'(`DPM_FREQ_LIM_MAX)))
		else $error("max frequency out of range");
	a_base_below_max: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL7
		(set_r.base_freq >= 9'(`DPM_FREQ_LIM_MIN)) && (set_r.base_freq <= set_r.max_freq)) else $error("base above max");
	a_run_src_range: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL3
		(set_r.run_source >= 3'(`DPM_RUN_SRC_MIN)) && (set_r.run_source <= 3'(`DPM_RUN_SRC_MAX)))
		else $error("run source out of range");
	a_freq_src_code: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL2
		(set_r.freq_source <= 4'(`DPM_FREQ_SRC_MAX6)) || (set_r.freq_source == 4'(`DPM_FREQ_SRC_CALC)))
		else $error("bad frequency source");
	a_pair_range: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL5
		set_r.analog_pair <= 3'(`DPM_PAIR_MAX)) else $error("analog pair out of range");
	a_dir_write: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL4
		wr_dir |=> (set_r.reverse == $past(reg_wdata_i[0]))) else $error("direction not stored");
	a_brake_read: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL8
		(reg_rd_i && reg_addr_i == `DPM_BRAKE_LOAD) |=> (reg_rdata_o <= `DPM_BRAKE_MAX)) else $error("brake rate over scale");
	a_life_read: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL1
		(reg_rd_i && reg_addr_i == `DPM_LIFE_WARN) |=> (reg_rdata_o[15:2] == 14'h0000) && reg_ack_o)
		else $error("life warning bad bits");
	a_pair_read: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		(reg_rd_i && reg_addr_i == `DPM_PULSE_HI) ##2 (reg_rd_i && reg_addr_i == `DPM_PULSE_LO)
		|=> (reg_rdata_o == $past(pulse_r[15:0], 3))) else $error("wide pair not consistent");
	a_aux_range: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL6
		set_r.aux_role <= 2'(`DPM_AUX_MAX)) else $error("aux role out of range");

	// Handshake: one answer per strobe, nothing in between
	a_ack_follows: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		(reg_wr_i || reg_rd_i) |=> reg_ack_o)
		else $error("no ack after strobe");
	a_ack_only_strobe: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		!(reg_wr_i || reg_rd_i) |=> !reg_ack_o)
		else $error("ack without strobe");
	a_err_with_ack: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		reg_err_o |-> reg_ack_o)
		else $error("err without ack");
	a_rdata_holds: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without read");
	a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		(reg_rd_i && !rd_hit) |=> (reg_rdata_o == 16'h0000) && reg_err_o)
		else $error("unmapped read not refused");
	a_ro_write_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL8
		(reg_wr_i && reg_addr_i == `DPM_BRAKE_LOAD) |=> reg_err_o)
		else $error("read-only write accepted");
	a_life_bits: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL1
		(reg_rd_i && reg_addr_i == `DPM_LIFE_WARN) |=> (reg_rdata_o[1:0] == $past({mon_i.fan_slow, mon_i.cap_aged})))
		else $error("life warning bits wrong");
	a_brake_value: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL8
		(reg_rd_i && reg_addr_i == `DPM_BRAKE_LOAD && mon_i.brake_load <= `DPM_BRAKE_MAX) |=> (reg_rdata_o == $past(mon_i.brake_load)))
		else $error("brake rate not passed");
	a_brake_clamp: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL8
		(reg_rd_i && reg_addr_i == `DPM_BRAKE_LOAD && mon_i.brake_load > `DPM_BRAKE_MAX) |=> (reg_rdata_o == `DPM_BRAKE_MAX))
		else $error("brake rate not clamped");
	a_dir_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL4
		(reg_wr_i && reg_addr_i == `DPM_DIRECTION && !dir_ok) |=> $stable(set_r.reverse) && reg_err_o)
		else $error("bad direction accepted");
	a_fs_write: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL2
		wr_fs |=> (set_r.freq_source == $past(reg_wdata_i[3:0])))
		else $error("frequency source not stored");
	a_fs_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL2
		(reg_wr_i && reg_addr_i == `DPM_FREQ_SRC && !fs_ok) |=> $stable(set_r.freq_source) && reg_err_o)
		else $error("bad frequency source accepted");
	a_rs_write: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL3
		wr_rs |=> (set_r.run_source == $past(reg_wdata_i[2:0])))
		else $error("run source not stored");
	a_rs_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL3
		(reg_wr_i && reg_addr_i == `DPM_RUN_SRC && !rs_ok) |=> $stable(set_r.run_source) && reg_err_o)
		else $error("bad run source accepted");
	a_pair_write: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL5
		wr_ap |=> (set_r.analog_pair == $past(reg_wdata_i[2:0])))
		else $error("analog pair not stored");
	a_pair_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL5
		(reg_wr_i && reg_addr_i == `DPM_ANALOG_PAIR && !ap_ok) |=> $stable(set_r.analog_pair) && reg_err_o)
		else $error("bad analog pair accepted");
	a_aux_write: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL6
		wr_ar |=> (set_r.aux_role == $past(reg_wdata_i[1:0])))
		else $error("aux role not stored");
	a_aux_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL6
		(reg_wr_i && reg_addr_i == `DPM_AUX_ROLE && !ar_ok) |=> $stable(set_r.aux_role) && reg_err_o)
		else $error("bad aux role accepted");
	a_max_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL7
		(reg_wr_i && reg_addr_i == `DPM_MAX_FREQ && !mx_ok) |=> $stable(set_r.max_freq) && reg_err_o)
		else $error("bad max frequency accepted");
	a_base_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL7
		(reg_wr_i && reg_addr_i == `DPM_BASE_FREQ && !bs_ok) |=> $stable(set_r.base_freq) && reg_err_o)
		else $error("bad base frequency accepted");

	// Wide pairs: the high half waits in hold until the low half lands
	a_hold_capture: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		wr_hi |=> (hold_r == $past(reg_wdata_i)))
		else $error("high half not held");
	a_accel_commit: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		wr_acc |=> (set_r.accel_time == $past(wide_wr)))
		else $error("accel pair not committed");
	a_decel_commit: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		wr_dec |=> (set_r.decel_time == $past(wide_wr)))
		else $error("decel pair not committed");
	a_time_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		(reg_wr_i && reg_addr_i == `DPM_ACCEL_LO && !time_ok) |=> $stable(set_r.accel_time) && reg_err_o)
		else $error("bad accel time accepted");
	a_pulse_write_wins: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		wr_pl |=> (pulse_r == $past(wide_wr)))
		else $error("pulse write lost");
	a_pulse_incr: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RL9
		(pulse_inc_i && !wr_pl) |=> (pulse_r == $past(pulse_r) + 32'h0000_0001))
		else $error("pulse count not advanced");
endmodule // dpm_param_bank

// ---- bench/dpm_master_model.sv ----
/*
 Serial master model: one register access per strobe.
 Assumes the bank answers exactly one cycle after the strobe.
*/
`timescale 1ns/1ps
module dpm_master_model (
	// Clock
	input  wire logic        sys_clk_i,
	// Access towards the bank
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic [15:0]      reg_addr_o,
	output logic [15:0]      reg_wdata_o,
	input  wire logic [15:0] reg_rdata_i,
	input  wire logic        reg_ack_i,
	input  wire logic        reg_err_i
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 16'h0000;
		reg_wdata_o = 16'h0000;
	end
	task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q, output logic e, k);
		@(posedge sys_clk_i);
		reg_wr_o <= w;
		reg_rd_o <= !w;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge sys_clk_i);
		// Released lines change, so a stale value cannot pass for a held one
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
		#1;
		q = reg_rdata_i;
		e = reg_err_i;
		k = reg_ack_i;
	endtask
endmodule // dpm_master_model

// ---- bench/tb.sv ----
/*
 Self-checking bench of the drive parameter bank.
 Assumes the register map header and package are compiled first.
*/
`timescale 1ns/1ps
`include "dpm_regs.svh"
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin n_errors++; $display("MISMATCH %s exp %h got %h", n, x, g); end end
module tb
	import dpm_pkg::*;
;
	logic         sys_clk_i = 1'b0;
	logic         srst_i = 1'b1;
	logic         pulse_inc_i = 1'b0;
	logic         wr, rd, ack, err, e, k;
	logic [15:0]  addr, wdata, rdata, q, lo;
	logic [31:0]  pulse_count_o;
	dpm_monitor_t mon_i = '0;
	dpm_setting_t set_o;
	int           n_errors = 0;
	int           cmp_count = 0;
	logic [15:0]  shd [logic [15:0]];
	logic [15:0]  ta [7] = '{`DPM_FREQ_SRC, `DPM_RUN_SRC, `DPM_DIRECTION, `DPM_ANALOG_PAIR, `DPM_AUX_ROLE,
		`DPM_BASE_FREQ, `DPM_MAX_FREQ};
	logic [15:0]  fa [9] = '{`DPM_MAX_FREQ, `DPM_MAX_FREQ, `DPM_MAX_FREQ, `DPM_BASE_FREQ, `DPM_BASE_FREQ,
		`DPM_MAX_FREQ, `DPM_BASE_FREQ, `DPM_MAX_FREQ, `DPM_BASE_FREQ};
	logic [15:0]  fv [9] = '{16'h001d, 16'h0190, 16'h0191, 16'h0191, 16'h0190, 16'h018f, 16'h001e, 16'h001e, 16'h001d};

	always #2.5 sys_clk_i = ~sys_clk_i;

	dpm_master_model u_dpm_master_model (.sys_clk_i(sys_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_ack_i(ack), .reg_err_i(err));
	dpm_param_bank u_dpm_param_bank (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
		.mon_i(mon_i), .pulse_inc_i(pulse_inc_i), .set_o(set_o), .pulse_count_o(pulse_count_o));

	task automatic test_done();
		if (n_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [15:0] a, d, input logic x);
		u_dpm_master_model.xfer(w, a, d, q, e, k);
		`CHK("ack", 1'b1, k)
		`CHK("err", x, e)
	endtask
	task automatic rdc(input logic [15:0] a, x);
		acc(1'b0, a, 16'h0000, 1'b0);
		`CHK("rdata", x, q)
	endtask
	// Legal codes and ranges of the settings
	function automatic logic ok(input logic [15:0] a, v);
		case (a)
			`DPM_FREQ_SRC: ok = v <= `DPM_FREQ_SRC_MAX6 || v == `DPM_FREQ_SRC_CALC;
			`DPM_RUN_SRC: ok = v >= `DPM_RUN_SRC_MIN && v <= `DPM_RUN_SRC_MAX;
			`DPM_DIRECTION: ok = v <= 16'h0001;
			`DPM_ANALOG_PAIR: ok = v <= `DPM_PAIR_MAX;
			`DPM_AUX_ROLE: ok = v <= `DPM_AUX_MAX;
			`DPM_MAX_FREQ: ok = v >= `DPM_FREQ_LIM_MIN && v <= `DPM_FREQ_LIM_MAX && v >= shd[`DPM_BASE_FREQ];
			`DPM_BASE_FREQ: ok = v >= `DPM_FREQ_LIM_MIN && v <= shd[`DPM_MAX_FREQ];
			default: ok = 1'b0;
		endcase
	endfunction
	task automatic setw(input logic [15:0] a, v);
		logic g;
		g = ok(a, v);
		acc(1'b1, a, v, !g);
		if (g) shd[a] = v;
		rdc(a, shd[a]);
	endtask
	task automatic mon_rand();
		logic [255:0] r;
		dpm_monitor_t m;
		for (int i = 0; i < 8; i++) r[i*32 +: 32] = $urandom();
		m = r[241:0];
		m.brake_load = 16'($urandom_range(0, 1100));
		@(posedge sys_clk_i);
		mon_i <= m;
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_errors++;
		test_done();
	end

	initial begin
		void'($urandom(32'hd67644c8));
		foreach (ta[i]) shd[ta[i]] = 16'h0000;
		shd[`DPM_RUN_SRC] = `DPM_RUN_SRC_MIN;
		shd[`DPM_BASE_FREQ] = `DPM_RST_BASE;
		shd[`DPM_MAX_FREQ] = `DPM_RST_MAX;
		repeat (6) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		#1;
		`CHK("accel_rst", `DPM_RST_ACCEL, set_o.accel_time)
		for (int i = 0; i < 5; i++) for (int v = 0; v < 12; v++) setw(ta[i], 16'(v));
		for (int i = 0; i < 9; i++) setw(fa[i], fv[i]);
		repeat (60) setw(ta[$urandom_range(0, 6)], 16'($urandom_range(0, 410)));
		`CHK("reverse", shd[`DPM_DIRECTION][0], set_o.reverse)
		`CHK("max", shd[`DPM_MAX_FREQ][8:0], set_o.max_freq)
		repeat (20) begin
			mon_rand();
			rdc(`DPM_BRAKE_LOAD, mon_i.brake_load > `DPM_BRAKE_MAX ? `DPM_BRAKE_MAX : mon_i.brake_load);
			rdc(`DPM_LIFE_WARN, {14'h0000, mon_i.fan_slow, mon_i.cap_aged});
			rdc(`DPM_ENERGY_HI, mon_i.energy_total[31:16]);
			lo = mon_i.energy_total[15:0];
			mon_rand();
			rdc(`DPM_ENERGY_LO, lo);
		end
		acc(1'b1, `DPM_BRAKE_LOAD, 16'h0000, 1'b1);
		acc(1'b0, 16'h101b, 16'h0000, 1'b1);
		`CHK("unmapped", 16'h0000, q)
		acc(1'b1, `DPM_ACCEL_HI, 16'h0005, 1'b0);
		acc(1'b1, `DPM_ACCEL_LO, 16'h7e40, 1'b0);
		`CHK("accel", `DPM_TIME_MAX, set_o.accel_time)
		acc(1'b1, `DPM_ACCEL_HI, 16'h0005, 1'b0);
		acc(1'b1, `DPM_ACCEL_LO, 16'h7e41, 1'b1);
		rdc(`DPM_ACCEL_HI, 16'h0005);
		rdc(`DPM_ACCEL_LO, 16'h7e40);
		acc(1'b1, `DPM_DECEL_HI, 16'h0000, 1'b0);
		acc(1'b1, `DPM_DECEL_LO, 16'h0001, 1'b0);
		`CHK("decel", `DPM_TIME_MIN, set_o.decel_time)
		acc(1'b1, `DPM_PULSE_HI, 16'h0000, 1'b0);
		acc(1'b1, `DPM_PULSE_LO, 16'hfffe, 1'b0);
		@(posedge sys_clk_i);
		pulse_inc_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		pulse_inc_i <= 1'b0;
		rdc(`DPM_PULSE_HI, 16'h0001);
		rdc(`DPM_PULSE_LO, 16'h0001);
		`CHK("pulse_count", 32'h0001_0001, pulse_count_o)
		test_done();
	end
endmodule // tb
